// ### src/hbd_ctrl.sv
// Motion controller end: sign/magnitude or anti-phase PWM, current limit in sign/magnitude mode only, thermal interrupt.
module hbd_ctrl #(
  parameter int unsigned PWM_PERIOD_CYCLES = hbd_pkg::PWM_PERIOD_CYC
) (
  input wire logic mclk,
  input wire logic srst,
  hbd_link_if.ctrl link,
  input wire logic lap_mode,
  input wire logic sign,
  input wire logic [hbd_pkg::MAG_BITS-1:0] magnitude,
  input wire logic hf_tick,
  input wire logic current_over,
  output logic thermal_irq
);

  localparam int unsigned CW = $clog2(PWM_PERIOD_CYCLES);
  localparam int unsigned PW = CW + hbd_pkg::MAG_BITS;
  localparam logic [CW-1:0] CNT_LAST = CW'(PWM_PERIOD_CYCLES - 1);
  localparam logic [PW-1:0] PERIOD_W = PW'(PWM_PERIOD_CYCLES);

  if (PWM_PERIOD_CYCLES < 2) begin : g_bad_period
    $error("PWM_PERIOD_CYCLES must be at least two");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Duty generator

  logic [CW-1:0] cnt_reg;
  logic [PW-1:0] prod;
  logic [CW-1:0] thresh;
  logic duty_on;

  always_ff @(posedge mclk) begin
    if (srst || cnt_reg == CNT_LAST) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + CW'(1);
    end
  end

  // Threshold is magnitude/128 of the period
  assign prod = PW'(magnitude) * PERIOD_W;
  assign thresh = prod[PW-1:hbd_pkg::MAG_BITS];
  assign duty_on = (cnt_reg < thresh);

  ////////////////////////////////////////////////////////////////////////////
  // Current-limit flop and overcurrent synchroniser

  logic oc1_reg;
  logic oc2_reg;
  logic limit_reg;

  always_ff @(posedge mclk) begin
    if (srst) begin
      oc1_reg <= 1'b0;
      oc2_reg <= 1'b0;
    end else begin
      oc1_reg <= current_over;
      oc2_reg <= oc1_reg;
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge mclk) begin
    if (srst) begin
      limit_reg <= 1'b0;
    end else if (hf_tick) begin
      limit_reg <= 1'b1;
    end else if (oc2_reg) begin
      limit_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link drive

  logic dir_reg;
  logic pwm_reg;

  always_ff @(posedge mclk) begin
    if (srst) begin
      dir_reg <= hbd_pkg::SIGN_FWD;
      pwm_reg <= 1'b0;
    end else if (lap_mode) begin
      dir_reg <= duty_on;
      pwm_reg <= hbd_pkg::LEVEL_ON;
    end else begin
      dir_reg <= sign;
      pwm_reg <= duty_on && limit_reg;
    end
  end

  assign link.dir = dir_reg;
  assign link.pwm = pwm_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Thermal flag to interrupt

  logic tf1_reg;
  logic tf2_reg;

  always_ff @(posedge mclk) begin
    if (srst) begin
      tf1_reg <= 1'b0;
      tf2_reg <= 1'b0;
    end else begin
      tf1_reg <= link.thermal_flag;
      tf2_reg <= tf1_reg;
    end
  end

  assign thermal_irq = tf2_reg;

endmodule : hbd_ctrl

// ### src/hbd_drive.sv
// Bridge drive end: input decode, dead band and protection sequencing.
// What this block does
// - Direction holds one high switch on continuously
// - Inactive PWM phase turns both high switches on
// - Controller makes 7-bit PWM at 15.625 kHz
// - Controller supplies one sign bit for direction
// - Half duty gives zero net drive
// - Dead band of 120 ns (three 40 ns cycles) per leg
// - Thermal flag raised above warning temperature
// - Overtemperature disables every switch
// - Overcurrent turns switches off 8 us, retries
// - No drive until supply reaches lockout threshold
// - Anti-phase: PWM held high, direction modulated
// - Anti-phase swaps diagonal pairs at period start and at the duty threshold
// - Accept sign/magnitude PWM up to 16 kHz
// - Thermal flag routed to controller interrupt
// - Current-limit flop set by clock, cleared by overcurrent
module hbd_drive #(
  parameter int unsigned DEAD_CYCLES = hbd_pkg::DEAD_CYC,
  parameter int unsigned RETRY_CYCLES = hbd_pkg::RETRY_CYC
) (
  input wire logic mclk,
  input wire logic srst,
  hbd_link_if.drv link,
  input wire logic temp_warn_cmp,
  input wire logic temp_shut_cmp,
  input wire logic over_current_cmp,
  input wire logic supply_ok_cmp,
  output logic side_a_high_switch,
  output logic side_a_low_switch,
  output logic side_b_high_switch,
  output logic side_b_low_switch,
  output logic thermal_shutdown,
  output logic current_retry,
  output logic undervoltage_lockout
);

  localparam int unsigned DW = $clog2(DEAD_CYCLES + 1);
  localparam int unsigned RW = $clog2(RETRY_CYCLES + 1);
  localparam logic [DW-1:0] DEAD_LAST = DW'(DEAD_CYCLES);
  localparam logic [RW-1:0] RETRY_LAST = RW'(RETRY_CYCLES - 1);

  if (DEAD_CYCLES < 1) begin : g_bad_dead
    $error("DEAD_CYCLES must be at least one");
  end
  if (RETRY_CYCLES < 1) begin : g_bad_retry
    $error("RETRY_CYCLES must be at least one");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  logic [hbd_pkg::SY_COUNT-1:0] raw_in;
  logic [hbd_pkg::SY_COUNT-1:0] sync1_reg;
  logic [hbd_pkg::SY_COUNT-1:0] sync2_reg;

  always_comb begin
    raw_in = '0;
    raw_in[hbd_pkg::SY_DIR] = link.dir;
    raw_in[hbd_pkg::SY_PWM] = link.pwm;
    raw_in[hbd_pkg::SY_WARN] = temp_warn_cmp;
    raw_in[hbd_pkg::SY_SHUT] = temp_shut_cmp;
    raw_in[hbd_pkg::SY_OC] = over_current_cmp;
    raw_in[hbd_pkg::SY_SUPPLY] = supply_ok_cmp;
  end

  for (genvar i = 0; i < hbd_pkg::SY_COUNT; i++) begin : g_sync
    always_ff @(posedge mclk) begin
      if (srst) begin
        sync1_reg[i] <= 1'b0;
        sync2_reg[i] <= 1'b0;
      end else begin
        sync1_reg[i] <= raw_in[i];
        sync2_reg[i] <= sync1_reg[i];
      end
    end
  end

  logic dir_s;
  logic pwm_s;
  logic warn_s;
  logic shut_s;
  logic oc_s;
  logic supply_s;

  assign dir_s = sync2_reg[hbd_pkg::SY_DIR];
  assign pwm_s = sync2_reg[hbd_pkg::SY_PWM];
  assign warn_s = sync2_reg[hbd_pkg::SY_WARN];
  assign shut_s = sync2_reg[hbd_pkg::SY_SHUT];
  assign oc_s = sync2_reg[hbd_pkg::SY_OC];
  assign supply_s = sync2_reg[hbd_pkg::SY_SUPPLY];

  ////////////////////////////////////////////////////////////////////////////
  // Protection sequencing

  hbd_pkg::hbd_state_t state_reg;
  hbd_pkg::hbd_state_t state_next;
  logic [RW-1:0] retry_cnt_reg;

  always_comb begin
    state_next = state_reg;
    if (!supply_s) begin
      state_next = hbd_pkg::st_lockout;
    end else begin
      unique case (state_reg)
        hbd_pkg::st_lockout: begin
          state_next = hbd_pkg::st_run;
        end
        hbd_pkg::st_run: begin
          if (shut_s) begin
            state_next = hbd_pkg::st_thermal;
          end else if (oc_s) begin
            state_next = hbd_pkg::st_retry;
          end
        end
        hbd_pkg::st_thermal: begin
          if (!shut_s) begin
            state_next = hbd_pkg::st_run;
          end
        end
        hbd_pkg::st_retry: begin
          if (shut_s) begin
            state_next = hbd_pkg::st_thermal;
          end else if (retry_cnt_reg == RETRY_LAST) begin
            state_next = hbd_pkg::st_run;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state_reg <= hbd_pkg::st_lockout;
    end else begin
      state_reg <= state_next;
    end
  end

  // Off time of the overcurrent retry
  always_ff @(posedge mclk) begin
    if (srst) begin
      retry_cnt_reg <= '0;
    end else if (state_reg == hbd_pkg::st_retry) begin
      retry_cnt_reg <= retry_cnt_reg + RW'(1);
    end else begin
      retry_cnt_reg <= '0;
    end
  end

  logic drive_en;
  assign drive_en = (state_reg == hbd_pkg::st_run);

  ////////////////////////////////////////////////////////////////////////////
  // Switch decode and dead band

  // Pattern covers sign/magnitude and locked anti-phase alike;
  // pwm held high makes dir swap the diagonal pairs.
  hbd_pkg::hbd_gate_t want;
  assign want = hbd_pkg::gate_decode(dir_s, pwm_s);

  logic [hbd_pkg::NUM_LEGS-1:0] hi_reg;
  logic [hbd_pkg::NUM_LEGS-1:0] lo_reg;

  for (genvar l = 0; l < hbd_pkg::NUM_LEGS; l++) begin : g_leg
    logic [DW-1:0] dead_cnt_reg;
    logic settled;

    // Counts cycles with both switches of the leg off
    assign settled = (dead_cnt_reg == DEAD_LAST);

    always_ff @(posedge mclk) begin
      if (srst) begin
        dead_cnt_reg <= '0;
      end else if (hi_reg[l] || lo_reg[l]) begin
        dead_cnt_reg <= '0;
      end else if (!settled) begin
        dead_cnt_reg <= dead_cnt_reg + DW'(1);
      end
    end

    // Off at once; on only after the dead band with the partner off
    always_ff @(posedge mclk) begin
      if (srst) begin
        hi_reg[l] <= 1'b0;
      end else if (!drive_en || !want[l].hi) begin
        hi_reg[l] <= 1'b0;
      end else if (!hi_reg[l] && !lo_reg[l] && settled) begin
        hi_reg[l] <= 1'b1;
      end
    end

    always_ff @(posedge mclk) begin
      if (srst) begin
        lo_reg[l] <= 1'b0;
      end else if (!drive_en || !want[l].lo) begin
        lo_reg[l] <= 1'b0;
      end else if (!hi_reg[l] && !lo_reg[l] && settled) begin
        lo_reg[l] <= 1'b1;
      end
    end
  end

  assign side_a_high_switch = hi_reg[hbd_pkg::LEG_A];
  assign side_a_low_switch = lo_reg[hbd_pkg::LEG_A];
  assign side_b_high_switch = hi_reg[hbd_pkg::LEG_B];
  assign side_b_low_switch = lo_reg[hbd_pkg::LEG_B];

  ////////////////////////////////////////////////////////////////////////////
  // Status

  logic flag_reg;
  logic tsd_reg;
  logic retry_reg;
  logic uvlo_reg;

  always_ff @(posedge mclk) begin
    if (srst) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= warn_s || shut_s;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      tsd_reg <= 1'b0;
      retry_reg <= 1'b0;
      uvlo_reg <= 1'b1;
    end else begin
      tsd_reg <= (state_next == hbd_pkg::st_thermal);
      retry_reg <= (state_next == hbd_pkg::st_retry);
      uvlo_reg <= (state_next == hbd_pkg::st_lockout);
    end
  end

  assign link.thermal_flag = flag_reg;
  assign thermal_shutdown = tsd_reg;
  assign current_retry = retry_reg;
  assign undervoltage_lockout = uvlo_reg;

endmodule : hbd_drive

// ### src/hbd_link_if.sv
// Link between the motion controller end and the bridge drive end.
interface hbd_link_if;
  logic dir;
  logic pwm;
  logic thermal_flag;

  modport ctrl (
    output dir,
    output pwm,
    input thermal_flag
  );

  modport drv (
    input dir,
    input pwm,
    output thermal_flag
  );
endinterface : hbd_link_if

// ### src/hbd_pkg.sv
// Shared constants, types and gate decoding for the H-bridge drive control.
package hbd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned DEADBAND_NS = 50;
  localparam int unsigned DEAD_CYC = (DEADBAND_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RETRY_NS = 8000;
  localparam int unsigned RETRY_CYC = RETRY_NS / CLK_PERIOD_NS;
  localparam int unsigned PWM_RATE_HZ = 15625;
  localparam int unsigned PWM_PERIOD_NS = 1000000000 / PWM_RATE_HZ;
  localparam int unsigned PWM_PERIOD_CYC = PWM_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned MAX_PWM_HZ = 16000;
  localparam int unsigned MIN_PWM_PERIOD_CYC = (1000000000 / MAX_PWM_HZ + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MAG_BITS = 7;

  ////////////////////////////////////////////////////////////////////////////
  // Encodings
  localparam logic SIGN_FWD = 1'b1;
  localparam logic LEVEL_ON = 1'b1;
  localparam int unsigned LEG_A = 0;
  localparam int unsigned LEG_B = 1;
  localparam int unsigned NUM_LEGS = 2;

  // Synchroniser slots in the drive end
  localparam int unsigned SY_DIR = 0;
  localparam int unsigned SY_PWM = 1;
  localparam int unsigned SY_WARN = 2;
  localparam int unsigned SY_SHUT = 3;
  localparam int unsigned SY_OC = 4;
  localparam int unsigned SY_SUPPLY = 5;
  localparam int unsigned SY_COUNT = 6;

  typedef struct packed {
    logic hi;
    logic lo;
  } hbd_leg_t;

  typedef hbd_leg_t [NUM_LEGS-1:0] hbd_gate_t;

  typedef enum logic [1:0] {
    st_lockout,
    st_run,
    st_thermal,
    st_retry
  } hbd_state_t;

  // Wanted switch pattern for a direction and PWM level
  function automatic hbd_gate_t gate_decode(input logic dir, input logic pwm);
    hbd_gate_t g;
    g = '0;
    if (pwm == LEVEL_ON) begin
      g[LEG_A].hi = dir;
      g[LEG_A].lo = ~dir;
      g[LEG_B].hi = ~dir;
      g[LEG_B].lo = dir;
    end else begin
      g[LEG_A].hi = 1'b1;
      g[LEG_B].hi = 1'b1;
    end
    return g;
  endfunction : gate_decode

endpackage : hbd_pkg

// ### tb/hbd_checker.sv
// Concurrent checks on the link, gate commands and protection states.
module hbd_checker #(
  parameter int unsigned RETRY_CYCLES = hbd_pkg::RETRY_CYC
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic dir,
  input wire logic pwm,
  input wire logic thermal_flag,
  input wire logic lap_mode,
  input wire logic temp_warn_cmp,
  input wire logic thermal_irq,
  input wire logic side_a_high_switch,
  input wire logic side_a_low_switch,
  input wire logic side_b_high_switch,
  input wire logic side_b_low_switch,
  input wire logic thermal_shutdown,
  input wire logic current_retry,
  input wire logic undervoltage_lockout
);
  timeunit 1ns;
  timeprecision 1ps;
  logic any_on;
  logic [15:0] retry_cnt_reg;
  assign any_on = side_a_high_switch | side_a_low_switch | side_b_high_switch | side_b_low_switch;
  // Cycles spent in the current off-time
  always_ff @(posedge mclk) begin
    if (srst || !current_retry) begin
      retry_cnt_reg <= 16'h0000;
    end else begin
      retry_cnt_reg <= retry_cnt_reg + 16'h0001;
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////////////////////
  a_leg_a_apart: assert property (!(side_a_high_switch && side_a_low_switch))
    else $error("leg A high and low on together");
  a_leg_b_apart: assert property (!(side_b_high_switch && side_b_low_switch))
    else $error("leg B high and low on together");
  a_dead_band_a: assert property ($rose(side_a_low_switch) |->
    !$past(side_a_high_switch, 1) && !$past(side_a_high_switch, 2) && !$past(side_a_high_switch, 3))
    else $error("leg A dead band too short");
  a_dead_band_b: assert property ($rose(side_b_low_switch) |->
    !$past(side_b_high_switch, 1) && !$past(side_b_high_switch, 2) && !$past(side_b_high_switch, 3))
    else $error("leg B dead band too short");
  a_warn_flag: assert property ($past(temp_warn_cmp, 3) && $past(temp_warn_cmp, 4) |-> thermal_flag)
    else $error("thermal flag missing");
  a_shut_off: assert property (thermal_shutdown && $past(thermal_shutdown) |-> !any_on)
    else $error("switch on in thermal shutdown");
  a_retry_off: assert property (current_retry && $past(current_retry) |-> !any_on)
    else $error("switch on during retry");
  a_retry_length: assert property ($fell(current_retry) && !thermal_shutdown && !undervoltage_lockout
    |-> retry_cnt_reg == 16'(RETRY_CYCLES))
    else $error("retry off time wrong");
  a_lockout_off: assert property (undervoltage_lockout && $past(undervoltage_lockout) |-> !any_on)
    else $error("switch on in lockout");
  a_lap_pwm_high: assert property (lap_mode && $past(lap_mode, 1) && $past(lap_mode, 2) |-> pwm)
    else $error("pwm low in anti-phase");
  a_irq_follows: assert property (thermal_irq == $past(thermal_flag, 2))
    else $error("interrupt does not follow flag");
  c_retry: cover property ($rose(current_retry));
  c_shutdown: cover property ($rose(thermal_shutdown));
  c_lap_dir: cover property ($rose(dir) && lap_mode);
endmodule : hbd_checker

// ### tb/hbridge_drive_control_test.sv
// Bench joining controller and drive ends, plus a drive fed directly.
module hbridge_drive_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PER = 32;
  localparam int RETRY = 4;
  logic mclk, srst, lap_mode, sign, hf_tick, current_over, thermal_irq;
  logic temp_warn_cmp, temp_shut_cmp, over_current_cmp, supply_ok_cmp;
  logic thermal_shutdown, current_retry, undervoltage_lockout;
  logic [hbd_pkg::MAG_BITS-1:0] magnitude;
  logic [3:0] sw_one, sw_two;
  logic [7:0] mon;
  integer seed = 62257;
  int compares = 0;
  int miscompares = 0;
  int c;
  hbd_link_if hbd_link_if_i ();
  hbd_link_if link_two ();
  hbd_ctrl #(.PWM_PERIOD_CYCLES(PER)) hbd_ctrl_i (.mclk, .srst, .link(hbd_link_if_i), .lap_mode, .sign,
    .magnitude, .hf_tick, .current_over, .thermal_irq);
  hbd_drive #(.RETRY_CYCLES(RETRY)) hbd_drive_i (.mclk, .srst, .link(hbd_link_if_i), .temp_warn_cmp,
    .temp_shut_cmp, .over_current_cmp, .supply_ok_cmp, .side_a_high_switch(sw_one[3]),
    .side_a_low_switch(sw_one[2]), .side_b_high_switch(sw_one[1]), .side_b_low_switch(sw_one[0]),
    .thermal_shutdown, .current_retry, .undervoltage_lockout);
  hbd_drive #(.RETRY_CYCLES(RETRY)) hbd_drive_probe_i (.mclk, .srst, .link(link_two), .temp_warn_cmp,
    .temp_shut_cmp, .over_current_cmp, .supply_ok_cmp, .side_a_high_switch(sw_two[3]),
    .side_a_low_switch(sw_two[2]), .side_b_high_switch(sw_two[1]), .side_b_low_switch(sw_two[0]),
    .thermal_shutdown(), .current_retry(), .undervoltage_lockout());
  hbd_checker #(.RETRY_CYCLES(RETRY)) hbd_checker_i (.mclk, .srst, .dir(hbd_link_if_i.dir),
    .pwm(hbd_link_if_i.pwm), .thermal_flag(hbd_link_if_i.thermal_flag), .lap_mode, .temp_warn_cmp,
    .thermal_irq, .side_a_high_switch(sw_one[3]), .side_a_low_switch(sw_one[2]),
    .side_b_high_switch(sw_one[1]), .side_b_low_switch(sw_one[0]), .thermal_shutdown, .current_retry,
    .undervoltage_lockout);
  // Bits: 0 flag, 1 irq, 2 shutdown, 3 retry, 4 lockout, 5 any switch, 6 pwm, 7 dir
  assign mon = {hbd_link_if_i.dir, hbd_link_if_i.pwm, |sw_one, undervoltage_lockout, current_retry,
    thermal_shutdown, thermal_irq, hbd_link_if_i.thermal_flag};
  always #20 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [3:0] exp_gate(input logic d, input logic p);
    return p ? {d, ~d, ~d, d} : 4'hA;
  endfunction : exp_gate
  function automatic logic [7:0] duty(input logic [6:0] m);
    return 8'((32'(m) * PER) >> 7);
  endfunction : duty
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic end_sim();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim
  task automatic wait_for(input int idx, input logic v, input int lim);
    int n;
    n = 0;
    while (mon[idx] !== v && n < lim) begin
      @(negedge mclk);
      n++;
    end
    if (mon[idx] !== v) begin
      miscompares++;
      $display("[FAIL] wait on %0d expected %h seen %h", idx, v, mon[idx]);
      end_sim();
    end
  endtask : wait_for
  task automatic count_high(input int idx, output int cnt);
    cnt = 0;
    repeat (PER) begin
      @(negedge mclk);
      cnt += int'(mon[idx]);
    end
  endtask : count_high
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    srst = 1'b1;
    {lap_mode, sign, hf_tick, current_over, temp_warn_cmp, temp_shut_cmp, over_current_cmp, supply_ok_cmp} = 8'h00;
    magnitude = 7'h7F;
    link_two.dir = 1'b1;
    link_two.pwm = 1'b0;
    repeat (16) @(posedge mclk);
    srst <= 1'b0;
    repeat (PER + 4) @(negedge mclk);
    chk("lockout", 8'h01, mon[4]);
    chk("switches", 8'h00, sw_two);
    count_high(6, c);
    chk("pwm before tick", 8'h00, 8'(c));
    @(posedge mclk);
    supply_ok_cmp <= 1'b1;
    hf_tick <= 1'b1;
    wait_for(4, 1'b0, 8);
    for (int i = 0; i < 5; i++) begin
      @(posedge mclk);
      link_two.dir <= i[0];
      link_two.pwm <= i[1] | i[2];
      repeat (12) @(negedge mclk);
      chk("pattern", exp_gate(i[0], i[1] | i[2]), sw_two);
    end
    @(posedge mclk);
    link_two.dir <= 1'b1;
    link_two.pwm <= 1'b0;
    repeat (12) @(posedge mclk);
    link_two.pwm <= 1'b1;
    @(posedge mclk);
    link_two.pwm <= 1'b0;
    repeat (10) begin
      @(negedge mclk);
      chk("narrow pulse", 8'h00, sw_two[0]);
    end
    repeat (300) begin
      @(posedge mclk);
      link_two.dir <= 1'($random(seed));
      link_two.pwm <= 1'($random(seed));
      @(negedge mclk);
      chk("shoot", 8'h00, {sw_two[3] & sw_two[2], sw_two[1] & sw_two[0]});
    end
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk);
      magnitude <= (i == 0) ? 7'h00 : (i == 1) ? 7'h7F : 7'($random(seed));
      sign <= 1'($random(seed));
      repeat (PER + 4) @(negedge mclk);
      count_high(6, c);
      chk("sm duty", duty(magnitude), 8'(c));
      chk("sign", sign, mon[7]);
    end
    @(posedge mclk);
    hf_tick <= 1'b0;
    current_over <= 1'b1;
    repeat (8) @(negedge mclk);
    count_high(6, c);
    chk("limited pwm", 8'h00, 8'(c));
    @(posedge mclk);
    hf_tick <= 1'b1;
    current_over <= 1'b0;
    lap_mode <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk);
      magnitude <= (i == 0) ? 7'h40 : 7'($random(seed));
      repeat (PER + 4) @(negedge mclk);
      count_high(6, c);
      chk("lap pwm", 8'(PER), 8'(c));
      count_high(7, c);
      chk("lap duty", duty(magnitude), 8'(c));
    end
    @(posedge mclk);
    temp_warn_cmp <= 1'b1;
    wait_for(0, 1'b1, 8);
    wait_for(1, 1'b1, 8);
    @(posedge mclk);
    temp_shut_cmp <= 1'b1;
    wait_for(2, 1'b1, 8);
    repeat (3) @(negedge mclk);
    chk("shut switches", 8'h00, sw_one);
    @(posedge mclk);
    temp_shut_cmp <= 1'b0;
    temp_warn_cmp <= 1'b0;
    wait_for(2, 1'b0, 8);
    wait_for(5, 1'b1, 20);
    @(posedge mclk);
    over_current_cmp <= 1'b1;
    @(posedge mclk);
    over_current_cmp <= 1'b0;
    wait_for(3, 1'b1, 8);
    count_high(3, c);
    chk("retry time", 8'(RETRY - 1), 8'(c));
    wait_for(5, 1'b1, 20);
    @(posedge mclk);
    supply_ok_cmp <= 1'b0;
    wait_for(4, 1'b1, 8);
    repeat (2) @(negedge mclk);
    chk("low supply", 8'h00, sw_one);
    end_sim();
  end
endmodule : hbridge_drive_control_test
